// file: bench/test_dual_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_comparator_control;
  import cmp_pkg::*;
  // ****************************************
  // Bench signals and the design instance.
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] cmp_raw = 2'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic rst_req;
  logic [1:0] pwr;
  logic [1:0] pin;
  logic [1:0] h0p;
  logic [1:0] h0n;
  logic [1:0] h1p;
  logic [1:0] h1n;
  logic [32:0] expq[$];
  logic [3:0] h;
  logic [9:0] idx;
  int errors = 0;
  int checked = 0;
  int seed = 25;
  int cyc = 0;
  always #5 pclk = ~pclk;
  dual_comparator_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_raw(cmp_raw), .cmp_power_en(pwr), .cmp0_pos_hyst(h0p), .cmp0_neg_hyst(h0n), .cmp1_pos_hyst(h1p),
    .cmp1_neg_hyst(h1n), .cmp_pin_out(pin), .cmp0_reset_req(rst_req), .irq(irq));
  task tally_and_finish;
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk_read(input logic [32:0] act, input logic [32:0] exp);
    checked++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task chk_out(input logic [7:0] act, input logic [7:0] exp);
    @(negedge pclk);
    checked++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the completing edge settle before anyone samples the outputs.
    @(negedge pclk);
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [9:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  task setraw(input int n, input logic v);
    @(posedge pclk);
    cmp_raw[n] <= v;
    repeat (8) @(posedge pclk);
  endtask
  // The monitor pairs each completed read with the oldest expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk_read({pslverr, prdata}, expq.pop_front());
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CTL0, 33'h0);
    rd(IDX_CTL1, 33'h0);
    rd(IDX_IRQ_STAT, 33'h0);
    rd(10'h3ff, 33'h1_0000_0000);
    for (int n = 0; n < 2; n++) begin
      for (int c = 0; c < 16; c++) begin
        wr(n ? IDX_CTL1 : IDX_CTL0, 32'(c));
        chk_out(n ? {4'h0, h1p, h1n} : {4'h0, h0p, h0n}, 8'(c));
      end
    end
    for (int n = 0; n < 2; n++) begin
      idx = n ? IDX_CTL1 : IDX_CTL0;
      h = 4'($random(seed));
      wr(IDX_IRQ_EN, 32'h0);
      wr(idx, {24'h0, 4'h8, h});
      chk_out({6'h0, pwr}, 8'(1 << n));
      setraw(n, 1'b0);
      setraw(n, 1'b1);
      rd(idx, {25'h0, 4'he, h});
      chk_out({6'h0, pin}, 8'(1 << n));
      chk_out({7'h0, irq}, 8'h0);
      wr(IDX_IRQ_EN, 32'(3 << (2 * n)));
      repeat (2) @(posedge pclk);
      chk_out({7'h0, irq}, 8'h1);
      setraw(n, 1'b0);
      rd(idx, {25'h0, 4'hb, h});
      rd(IDX_IRQ_STAT, 33'(3 << (2 * n)));
      wr(IDX_IRQ_CLR, 32'(1 << (2 * n)));
      rd(IDX_IRQ_STAT, 33'(2 << (2 * n)));
      rd(idx, {25'h0, 4'ha, h});
      wr(idx, {24'h0, 4'h8, h});
      rd(idx, {25'h0, 4'h8, h});
      repeat (2) @(posedge pclk);
      chk_out({7'h0, irq}, 8'h0);
      wr(idx, 32'h0);
      setraw(n, 1'b1);
      rd(idx, 33'h0);
      chk_out({6'h0, pin}, 8'h0);
      chk_out({7'h0, irq}, 8'h0);
      setraw(n, 1'b0);
    end
    wr(IDX_RST_SRC, 32'h1);
    wr(IDX_CTL1, 32'h80);
    setraw(1, 1'b0);
    chk_out({7'h0, rst_req}, 8'h0);
    wr(IDX_CTL0, 32'h80);
    setraw(0, 1'b0);
    chk_out({7'h0, rst_req}, 8'h1);
    setraw(0, 1'b1);
    chk_out({7'h0, rst_req}, 8'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// file: pkg/cmp_pkg.sv
package cmp_pkg;
  localparam int unsigned NCMP = 2;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned IRQ_W = 4;
  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_CTL0 = 10'h09e;
  localparam logic [9:0] IDX_CTL1 = 10'h09f;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0a0;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h0a1;
  localparam logic [9:0] IDX_IRQ_EN = 10'h0a2;
  localparam logic [9:0] IDX_RST_SRC = 10'h0a3;
  // Control register fields.
  localparam int unsigned BIT_EN = 7;
  localparam int unsigned BIT_OUT = 6;
  localparam int unsigned BIT_RISE = 5;
  localparam int unsigned BIT_FALL = 4;
  localparam int unsigned POS_HI = 3;
  localparam int unsigned POS_LO = 2;
  localparam int unsigned NEG_HI = 1;
  localparam int unsigned NEG_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Interrupt layout: bit 2n is fall of comparator n, bit 2n+1 its rise.
  localparam int unsigned IRQ_FALL_OFS = 0;
  localparam int unsigned IRQ_RISE_OFS = 1;
  localparam int unsigned BIT_RST_SEL = 0;
  // Hysteresis codes.
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_2MV = 2'h1;
  localparam logic [1:0] HYST_4MV = 2'h2;
  localparam logic [1:0] HYST_10MV = 2'h3;
  // Power-up settling that software must respect after enabling.
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned POWER_UP_US = 20;
  localparam int unsigned POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
endpackage

// file: verilog/dual_comparator_control.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cmp_pkg::NCMP-1:0] cmp_raw,
  output logic [cmp_pkg::NCMP-1:0] cmp_power_en,
  output logic [1:0] cmp0_pos_hyst,
  output logic [1:0] cmp0_neg_hyst,
  output logic [1:0] cmp1_pos_hyst,
  output logic [1:0] cmp1_neg_hyst,
  output logic [cmp_pkg::NCMP-1:0] cmp_pin_out,
  output logic cmp0_reset_req,
  output logic irq
);
  import cmp_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [NCMP-1:0] en_r;
  logic [NCMP-1:0] out_r;
  logic [NCMP-1:0] rise_r;
  logic [NCMP-1:0] fall_r;
  logic [1:0] pos_r [NCMP];
  logic [1:0] neg_r [NCMP];
  logic [IRQ_W-1:0] irq_en_r;
  logic rst_sel_r;
  logic irq_r;
  logic rst_req_r;
  logic [NCMP-1:0] pin_r;
  logic [NCMP-1:0] s1_r;
  logic [NCMP-1:0] s2_r;
  logic [NCMP-1:0] s3_r;
  logic [NCMP-1:0] rise_ev;
  logic [NCMP-1:0] fall_ev;
  logic setup;
  logic wr_done;
  logic [NCMP-1:0] wr_ctl;
  logic wr_clr;
  logic mapped;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] stat;

  assign setup = psel && !penable && !pready_r;
  assign wr_done = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wr_ctl[0] = wr_done && hit(paddr, IDX_CTL0);
  assign wr_ctl[1] = wr_done && hit(paddr, IDX_CTL1);
  assign wr_clr = wr_done && hit(paddr, IDX_IRQ_CLR);

  always_comb begin
    stat = {rise_r[1], fall_r[1], rise_r[0], fall_r[0]};
    mapped = 1'b1;
    rd_mux = 32'h0;
    if (hit(paddr, IDX_CTL0)) begin
      rd_mux[7:0] = {en_r[0], out_r[0], rise_r[0], fall_r[0], pos_r[0], neg_r[0]};
    end else if (hit(paddr, IDX_CTL1)) begin
      rd_mux[7:0] = {en_r[1], out_r[1], rise_r[1], fall_r[1], pos_r[1], neg_r[1]};
    end else if (hit(paddr, IDX_IRQ_STAT)) begin
      rd_mux[IRQ_W-1:0] = stat;
    end else if (hit(paddr, IDX_IRQ_EN)) begin
      rd_mux[IRQ_W-1:0] = irq_en_r;
    end else if (hit(paddr, IDX_RST_SRC)) begin
      rd_mux[BIT_RST_SEL] = rst_sel_r;
    end else if (!hit(paddr, IDX_IRQ_CLR)) begin
      mapped = 1'b0;
    end
  end

  // The answer comes one cycle after setup; the clear register reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite && mapped) begin
        prdata_r <= rd_mux;
      end else if (setup) begin
        prdata_r <= 32'h0;
      end
    end
  end

  // ****************************************
  // Per-comparator logic
  // ****************************************
  genvar n;
  generate
    for (n = 0; n < NCMP; n++) begin : g_cmp
      // The first stage feeds only the second.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[n] <= 1'b0;
          s2_r[n] <= 1'b0;
          s3_r[n] <= 1'b0;
        end else begin
          s1_r[n] <= cmp_raw[n];
          s2_r[n] <= s1_r[n];
          s3_r[n] <= s2_r[n];
        end
      end

      // Edges count only while enabled, so enabling never fakes an edge.
      assign rise_ev[n] = en_r[n] && s2_r[n] && !s3_r[n] && out_r[n] == s3_r[n];
      assign fall_ev[n] = en_r[n] && !s2_r[n] && s3_r[n] && out_r[n] == s3_r[n];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en_r[n] <= CTL_RESET[BIT_EN];
          pos_r[n] <= CTL_RESET[POS_HI:POS_LO];
          neg_r[n] <= CTL_RESET[NEG_HI:NEG_LO];
        end else if (wr_ctl[n]) begin
          en_r[n] <= pwdata[BIT_EN];
          pos_r[n] <= pwdata[POS_HI:POS_LO];
          neg_r[n] <= pwdata[NEG_HI:NEG_LO];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_r[n] <= 1'b0;
          pin_r[n] <= 1'b0;
        end else begin
          out_r[n] <= en_r[n] && s2_r[n];
          pin_r[n] <= en_r[n] && s2_r[n];
        end
      end

      // A new edge wins over a clear in the same cycle.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rise_r[n] <= CTL_RESET[BIT_RISE];
          fall_r[n] <= CTL_RESET[BIT_FALL];
        end else begin
          if (rise_ev[n]) begin
            rise_r[n] <= 1'b1;
          end else if ((wr_ctl[n] && !pwdata[BIT_RISE]) || (wr_clr && pwdata[2*n+IRQ_RISE_OFS])) begin
            rise_r[n] <= 1'b0;
          end
          if (fall_ev[n]) begin
            fall_r[n] <= 1'b1;
          end else if ((wr_ctl[n] && !pwdata[BIT_FALL]) || (wr_clr && pwdata[2*n+IRQ_FALL_OFS])) begin
            fall_r[n] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Interrupt and reset source
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= IRQ_RESET;
      rst_sel_r <= 1'b0;
    end else begin
      if (wr_done && hit(paddr, IDX_IRQ_EN)) begin
        irq_en_r <= pwdata[IRQ_W-1:0];
      end
      if (wr_done && hit(paddr, IDX_RST_SRC)) begin
        rst_sel_r <= pwdata[BIT_RST_SEL];
      end
    end
  end

  // Reset is requested while comparator 0 is enabled, selected and low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      rst_req_r <= 1'b0;
    end else begin
      irq_r <= |(stat & irq_en_r);
      rst_req_r <= rst_sel_r && en_r[0] && !s2_r[0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cmp_power_en = en_r;
  assign cmp0_pos_hyst = pos_r[0];
  assign cmp0_neg_hyst = neg_r[0];
  assign cmp1_pos_hyst = pos_r[1];
  assign cmp1_neg_hyst = neg_r[1];
  assign cmp_pin_out = pin_r;
  assign cmp0_reset_req = rst_req_r;
  assign irq = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rise_in(int i);
    !s2_r[i] ##1 s2_r[i] && en_r[i];
  endsequence

  a_power_follows: assert property (wr_ctl[0] |=> cmp_power_en[0] == $past(pwdata[BIT_EN]))
    else $error("enable bit not applied to power");
  a_disabled_pin_low: assert property (!en_r[0] ##1 !en_r[0] |-> !cmp_pin_out[0])
    else $error("pin high while disabled");
  a_no_edge_off: assert property (!en_r[1] |=> $stable(rise_r[1]) || !rise_r[1])
    else $error("flag set while disabled");
  a_rise_flag_set: assert property (s_rise_in(0) ##1 (en_r[0] && !wr_ctl[0] && !wr_clr) |=> rise_r[0])
    else $error("rising edge lost");
  a_fall_flag_set: assert property (s3_r[1] && !s2_r[1] && en_r[1] && out_r[1] |=> fall_r[1])
    else $error("falling edge lost");
  a_flag_sticky: assert property (rise_r[0] && !wr_ctl[0] && !wr_clr |=> rise_r[0])
    else $error("flag dropped without clear");
  a_state_read: assert property (en_r[0] ##1 en_r[0] |-> out_r[0] == $past(s2_r[0]))
    else $error("state bit wrong");
  a_hyst_code: assert property (wr_ctl[1] |=> cmp1_pos_hyst == $past(pwdata[POS_HI:POS_LO]))
    else $error("hysteresis code not applied");
  a_neg_hyst: assert property (wr_ctl[0] |=> cmp0_neg_hyst == $past(pwdata[NEG_HI:NEG_LO]))
    else $error("negative code not applied");
  a_reset_src: assert property (!rst_sel_r |=> !cmp0_reset_req)
    else $error("reset request without select");
  a_sync_delay: assert property (s2_r[1] == $past(s1_r[1]))
    else $error("synchroniser depth wrong");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
  a_irq_level: assert property (|(stat & irq_en_r) |=> irq)
    else $error("interrupt not raised");

  // ****************************************
  // Flag, state, hysteresis, routing and reset source checks for both comparators
  // ****************************************

  sequence s_fall_in(int i);
    s2_r[i] && en_r[i] ##1 !s2_r[i] && en_r[i];
  endsequence

  // Power and disabled behaviour of both comparators.
  a_power1_follows: assert property (wr_ctl[1] |=> cmp_power_en[1] == $past(pwdata[BIT_EN]))
    else $error("enable bit not applied to power");
  a_pin1_low: assert property (!en_r[1] ##1 !en_r[1] |-> !cmp_pin_out[1])
    else $error("pin high while disabled");
  a_no_fall_off: assert property (!en_r[0] |=> $stable(fall_r[0]) || !fall_r[0])
    else $error("flag set while disabled");

  // Edge flags are set by edges and kept until cleared.
  a_rise1_set: assert property (s_rise_in(1) ##1 (en_r[1] && !wr_ctl[1] && !wr_clr) |=> rise_r[1])
    else $error("rising edge lost");
  a_fall0_set: assert property (s_fall_in(0) ##1 (!wr_ctl[0] && !wr_clr) |=> fall_r[0])
    else $error("falling edge lost");
  a_fall1_set: assert property (s_fall_in(1) ##1 (!wr_ctl[1] && !wr_clr) |=> fall_r[1])
    else $error("falling edge lost");
  a_rise_wins: assert property (rise_ev[0] |=> rise_r[0])
    else $error("edge lost against clear");
  a_fall_wins: assert property (fall_ev[1] |=> fall_r[1])
    else $error("edge lost against clear");
  a_fall_sticky: assert property (fall_r[1] && !wr_ctl[1] && !wr_clr |=> fall_r[1])
    else $error("flag dropped without clear");
  a_clear_reg: assert property (wr_clr && pwdata[IRQ_FALL_OFS] && !fall_ev[0] |=> !fall_r[0])
    else $error("clear register ignored");
  a_ctl_clear: assert property (wr_ctl[0] && !pwdata[BIT_RISE] && !rise_ev[0] |=> !rise_r[0])
    else $error("control write clear ignored");
  a_edge_irq: assert property (rise_r[0] && irq_en_r[IRQ_RISE_OFS] |=> irq)
    else $error("edge interrupt not raised");
  a_irq_drop: assert property (!(|(stat & irq_en_r)) |=> !irq)
    else $error("interrupt without enabled flag");

  // State, hysteresis, routing and reset source.
  a_state1_read: assert property (en_r[1] ##1 en_r[1] |-> out_r[1] == $past(s2_r[1]))
    else $error("state bit wrong");
  a_hyst0_pos: assert property (wr_ctl[0] |=> cmp0_pos_hyst == $past(pwdata[POS_HI:POS_LO]))
    else $error("hysteresis code not applied");
  a_hyst1_neg: assert property (wr_ctl[1] |=> cmp1_neg_hyst == $past(pwdata[NEG_HI:NEG_LO]))
    else $error("negative code not applied");
  a_pin_follows: assert property (en_r[0] |=> cmp_pin_out[0] == $past(s2_r[0]))
    else $error("pin does not follow output");
  a_reset_needs_en: assert property (!en_r[0] |=> !cmp0_reset_req)
    else $error("reset request while disabled");
  a_sync_first: assert property (s1_r[0] == $past(cmp_raw[0]))
    else $error("synchroniser first stage wrong");

  // Bus error answers only with ready.
  a_slverr_pulse: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
`default_nettype wire
